// ### rtl/spi_port_pkg.sv
// constants and types shared by the serial port design
package spi_port_pkg;

   // ==================================================
   // register map (apb byte addresses)
   localparam logic [3:0] ctrl_addr = 4'h0;
   localparam logic [3:0] stat_addr = 4'h4;
   localparam logic [3:0] data_addr = 4'h8;

   // ==================================================
   // control field positions
   localparam int ctl_sel_ign = 7;
   localparam int ctl_enable = 6;
   localparam int ctl_order = 5;
   localparam int ctl_role = 4;
   localparam int ctl_clock_polarity = 3;
   localparam int ctl_clock_phase = 2;

   // ==================================================
   // status field positions
   localparam int st_done = 7;
   localparam int st_write_collision_flag = 6;
   localparam int st_ovr = 5;
   localparam int st_fault = 4;

   // ==================================================
   // reset values and counts
   localparam logic [7:0] ctrl_reset = 8'h00;
   localparam logic [7:0] data_reset = 8'h00;
   localparam logic [7:0] idle_tx_byte = 8'h00;
   localparam int bits_per_byte = 8;

   // half periods of the master clock in system cycles: /4 /16 /64 /128
   localparam logic [6:0] half_div0 = 7'h02;
   localparam logic [6:0] half_div1 = 7'h08;
   localparam logic [6:0] half_div2 = 7'h20;
   localparam logic [6:0] half_div3 = 7'h40;

   typedef enum logic [1:0] {
      st_idle = 2'b00,
      st_lead = 2'b01,
      st_trail = 2'b11
   } master_state_t;

endpackage

// ### rtl/spi_shift_if.sv
// handshake between the register file and the shift engine
`timescale 1ns/10ps
interface spi_shift_if;
   logic load;
   logic [7:0] tx_byte;
   logic done;
   logic [7:0] rx_byte;
   logic busy;

   modport regs (output load, output tx_byte, input done, input rx_byte, input busy);
   modport engine (input load, input tx_byte, output done, output rx_byte, output busy);
endinterface

// ### rtl/spi_rate_div.sv
// master serial clock half-period enable divider
`timescale 1ns/10ps
module spi_rate_div (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   // control
   input wire logic run_i,
   input wire logic [1:0] rate_i,
   // enable
   output logic tick_o
);
   logic [6:0] cnt_ff;
   logic [6:0] half;

   always_comb begin
      unique case (rate_i)
         2'b00: half = spi_port_pkg::half_div0;
         2'b01: half = spi_port_pkg::half_div1;
         2'b10: half = spi_port_pkg::half_div2;
         2'b11: half = spi_port_pkg::half_div3;
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i || !run_i) begin
         cnt_ff <= 7'h00;
         tick_o <= 1'b0;
      end else if (cnt_ff == half - 7'h01) begin
         cnt_ff <= 7'h00;
         tick_o <= 1'b1;
      end else begin
         cnt_ff <= cnt_ff + 7'h01;
         tick_o <= 1'b0;
      end
   end
endmodule

// ### rtl/spi_port.sv
// serial peripheral port: apb registers, master and slave shift engine
// Operation
// R1: with select ignore clear, the select pin level decides the role
// R2: with select ignore set, role bit alone decides; select pin unused
// R3: port enable clear disables port and frees pins; set routes signals
// R4: bit order 0 shifts msb first, 1 lsb first, both directions
// R5: role bit 0 means slave, 1 means master
// R6: clock idles low for polarity 0, high for polarity 1
// R7: phase 0 samples on first clock edge, phase 1 on second
// R8: slave phase 0 drives first bit as soon as select falls
// R9: phase 1 drives each bit on the edge before its sample edge
// R10: master clock is system clock over 4, 16, 64 or 128
// R11: done flag set at byte end, write one clears it
// R12: data write while busy sets collision flag, shift byte kept
// R13: receive is double buffered; byte ending with done set sets overrun
// R14: overrun does not stop shifting in further data
// R15: select low on master sets fault flag and forces slave role
// R16: low four status bits read zero, writes ignored
// R17: data writes load shift register, reads return receive register
// R18: unloaded slave shifts out zero
// R19: fault also clears port enable and role bits
// R20: no fault while select ignore is set
// R21: unselected slave and idle master keep outputs undriven
// R22: software keeps phase 1 for slave with select ignore set
//
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module spi_port (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [3:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // serial pins
   input wire logic sck_i,
   output logic sck_o,
   output logic sck_oe_o,
   input wire logic mosi_i,
   output logic mosi_o,
   output logic mosi_oe_o,
   input wire logic miso_i,
   output logic miso_o,
   output logic miso_oe_o,
   input wire logic ss_n_i,
   // status
   output logic irq_o,
   output logic spi_active_o
);
   // ==================================================
   // registers
   logic [7:0] ctrl_ff;
   logic [3:0] stat_ff;
   logic [7:0] rx_ff;
   logic [7:0] sh_ff;
   logic [2:0] cnt_ff;
   logic sample_ff;
   logic sck_ff;
   logic sck_in_ff;
   logic ss_n_ff;
   logic busy_ff;
   logic done_ff;
   spi_port_pkg::master_state_t mst_ff;
   spi_shift_if sif ();

   logic sel_ign, enable, order, role, clock_polarity, clock_phase;
   logic is_master, slave_sel, tick;
   logic wr, fault;
   logic sck_rise, sck_fall, lead_edge, trail_edge;
   logic tx_bit, in_bit;

   assign sel_ign = ctrl_ff[spi_port_pkg::ctl_sel_ign];
   assign enable = ctrl_ff[spi_port_pkg::ctl_enable];
   assign order = ctrl_ff[spi_port_pkg::ctl_order];
   assign role = ctrl_ff[spi_port_pkg::ctl_role];
   assign clock_polarity = ctrl_ff[spi_port_pkg::ctl_clock_polarity];
   assign clock_phase = ctrl_ff[spi_port_pkg::ctl_clock_phase];
   assign is_master = enable && role; // R5
   assign slave_sel = enable && !role && (sel_ign || !ss_n_i); // R1 R2
   // select low while master and select honoured
   assign fault = is_master && !sel_ign && !ss_n_i; // R15 R20

   assign wr = psel_i && penable_i && pwrite_i;

   function automatic logic out_bit(input logic [7:0] b, input logic lsb);
      out_bit = lsb ? b[0] : b[7];
   endfunction

   function automatic logic [7:0] shift_in(input logic [7:0] b, input logic lsb,
                                           input logic d);
      shift_in = lsb ? {d, b[7:1]} : {b[6:0], d}; // R4
   endfunction

   // ==================================================
   // master clock divider
   spi_rate_div u_div (
      .ref_clk_i(ref_clk_i),
      .resetn_i(resetn_i),
      .run_i(mst_ff != spi_port_pkg::st_idle),
      .rate_i(ctrl_ff[1:0]),
      .tick_o(tick)
   ); // R10

   // ==================================================
   // apb register access
   assign sif.load = wr && paddr_i == spi_port_pkg::data_addr && !busy_ff;
   assign sif.tx_byte = pwdata_i[7:0];

   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         ctrl_ff <= spi_port_pkg::ctrl_reset;
      end else if (fault) begin
         ctrl_ff[spi_port_pkg::ctl_enable] <= 1'b0; // R19
         ctrl_ff[spi_port_pkg::ctl_role] <= 1'b0; // R15 R19
      end else if (wr && paddr_i == spi_port_pkg::ctrl_addr) begin
         ctrl_ff <= pwdata_i[7:0];
      end
   end

   // flags: stat_ff[3]=done [2]=collision [1]=overrun [0]=fault; set wins
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         stat_ff <= 4'h0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (wr && paddr_i == spi_port_pkg::stat_addr && pwdata_i[4 + i]) begin
               stat_ff[i] <= 1'b0;
            end
         end
         if (sif.done) begin
            stat_ff[3] <= 1'b1; // R11
         end
         if (wr && paddr_i == spi_port_pkg::data_addr && busy_ff) begin
            stat_ff[2] <= 1'b1; // R12
         end
         if (sif.done && stat_ff[3]) begin
            stat_ff[1] <= 1'b1; // R13 R14
         end
         if (fault) begin
            stat_ff[0] <= 1'b1; // R15
         end
      end
   end

   // receive buffer only takes a byte when the previous was acknowledged
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         rx_ff <= spi_port_pkg::data_reset;
      end else if (sif.done && !stat_ff[3]) begin
         rx_ff <= sif.rx_byte; // R13
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         prdata_o <= 32'h0000_0000;
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
      end else begin
         pready_o <= psel_i && !penable_i;
         pslverr_o <= psel_i && !penable_i && paddr_i != spi_port_pkg::ctrl_addr
                      && paddr_i != spi_port_pkg::stat_addr
                      && paddr_i != spi_port_pkg::data_addr;
         if (psel_i && !penable_i && !pwrite_i) begin
            unique case (paddr_i)
               spi_port_pkg::ctrl_addr: prdata_o <= {24'h000000, ctrl_ff};
               spi_port_pkg::stat_addr: prdata_o <= {24'h000000, stat_ff, 4'h0}; // R16
               spi_port_pkg::data_addr: prdata_o <= {24'h000000, rx_ff}; // R17
               default: prdata_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ==================================================
   // shift engine
   // slave edges come from the sampled serial clock; the master uses its own
   assign sck_rise = sck_i && !sck_in_ff;
   assign sck_fall = !sck_i && sck_in_ff;
   assign lead_edge = clock_polarity ? sck_fall : sck_rise;
   assign trail_edge = clock_polarity ? sck_rise : sck_fall;
   assign in_bit = is_master ? miso_i : mosi_i;
   assign tx_bit = out_bit(sh_ff, order);
   assign sif.busy = busy_ff;
   assign sif.done = done_ff;
   assign sif.rx_byte = sh_ff;

   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         sck_in_ff <= 1'b0;
         ss_n_ff <= 1'b1;
      end else begin
         sck_in_ff <= sck_i;
         ss_n_ff <= ss_n_i;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         sh_ff <= spi_port_pkg::idle_tx_byte; // R18
         cnt_ff <= 3'h0;
         sample_ff <= 1'b0;
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
         mst_ff <= spi_port_pkg::st_idle;
         sck_ff <= 1'b0;
      end else begin
         done_ff <= 1'b0;
         if (done_ff) begin
            sh_ff <= spi_port_pkg::idle_tx_byte; // R18
         end
         if (!enable || fault) begin
            busy_ff <= 1'b0; // R3
            mst_ff <= spi_port_pkg::st_idle;
            cnt_ff <= 3'h0;
            sck_ff <= clock_polarity;
         end else if (sif.load) begin
            sh_ff <= sif.tx_byte; // R17 R12
            if (is_master) begin
               busy_ff <= 1'b1;
               mst_ff <= spi_port_pkg::st_lead;
               sck_ff <= clock_polarity; // R6
            end
         end else if (is_master) begin
            sck_ff <= busy_ff ? sck_ff : clock_polarity; // R6
            if (tick) begin
               unique case (mst_ff)
                  spi_port_pkg::st_lead: begin
                     sck_ff <= !clock_polarity;
                     mst_ff <= spi_port_pkg::st_trail;
                     if (!clock_phase) begin
                        sample_ff <= in_bit; // R7
                     end else if (cnt_ff != 3'h0) begin
                        sh_ff <= shift_in(sh_ff, order, sample_ff); // R9
                     end
                  end
                  spi_port_pkg::st_trail: begin
                     sck_ff <= clock_polarity;
                     cnt_ff <= cnt_ff + 3'h1;
                     if (!clock_phase) begin
                        sh_ff <= shift_in(sh_ff, order, sample_ff);
                     end else begin
                        sample_ff <= in_bit; // R7
                     end
                     if (cnt_ff == 3'h7) begin
                        mst_ff <= spi_port_pkg::st_idle;
                        busy_ff <= 1'b0;
                        done_ff <= 1'b1; // R11
                        if (clock_phase) begin
                           sh_ff <= shift_in(sh_ff, order, in_bit);
                        end
                     end else begin
                        mst_ff <= spi_port_pkg::st_lead;
                     end
                  end
                  default: mst_ff <= spi_port_pkg::st_idle;
               endcase
            end
         end else if (!slave_sel) begin
            busy_ff <= 1'b0;
            cnt_ff <= 3'h0;
         end else if (lead_edge) begin
            busy_ff <= 1'b1;
            if (!clock_phase) begin
               sample_ff <= mosi_i; // R7
            end else if (cnt_ff != 3'h0 || busy_ff) begin
               sh_ff <= shift_in(sh_ff, order, sample_ff); // R9
            end
         end else if (trail_edge) begin
            if (!clock_phase) begin
               sh_ff <= shift_in(sh_ff, order, sample_ff); // R8
            end else begin
               sample_ff <= mosi_i; // R7
            end
            cnt_ff <= cnt_ff + 3'h1;
            if (cnt_ff == 3'h7) begin
               busy_ff <= 1'b0;
               done_ff <= 1'b1; // R11
               if (clock_phase) begin
                  sh_ff <= shift_in(sh_ff, order, mosi_i);
               end
            end
         end
      end
   end

   // ==================================================
   // pin drivers
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         sck_o <= 1'b0;
         sck_oe_o <= 1'b0;
         mosi_o <= 1'b0;
         mosi_oe_o <= 1'b0;
         miso_o <= 1'b0;
         miso_oe_o <= 1'b0;
         irq_o <= 1'b0;
         spi_active_o <= 1'b0;
      end else begin
         sck_o <= sck_ff;
         sck_oe_o <= is_master && busy_ff && !fault; // R21 R3
         mosi_o <= tx_bit;
         mosi_oe_o <= is_master && busy_ff && !fault; // R21
         miso_o <= tx_bit; // R8
         miso_oe_o <= slave_sel && !fault; // R21 R22
         irq_o <= stat_ff[3] || stat_ff[0];
         spi_active_o <= busy_ff;
      end
   end
endmodule

// ### dv/spi_port_asserts.sv
// concurrent checks on the serial port top level
`timescale 1ns/10ps
module spi_port_asserts (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   // apb
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [3:0] paddr_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   // serial
   input wire logic sck_o,
   input wire logic sck_oe_o,
   input wire logic mosi_oe_o,
   input wire logic miso_oe_o,
   input wire logic ss_n_i,
   input wire logic spi_active_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);
   logic mapped;
   assign mapped = paddr_i inside {spi_port_pkg::ctrl_addr, spi_port_pkg::stat_addr,
      spi_port_pkg::data_addr};
   // =====
   // bus answer
   a_ready_access: assert property (psel_i && !penable_i ##1 psel_i && penable_i |-> pready_o)
      else $error("no ready in access cycle");
   a_ready_single: assert property (pready_o |=> !pready_o) else $error("ready held");
   a_ready_cause: assert property (pready_o |-> psel_i && penable_i) else $error("stray ready");
   a_err_unmapped: assert property (pready_o && !mapped |-> pslverr_o) else $error("no error");
   a_err_mapped: assert property (pslverr_o |-> pready_o && !mapped) else $error("stray error");
   a_read_upper: assert property (pready_o && !pwrite_i |-> prdata_o[31:8] == 24'h000000)
      else $error("upper read bits set");
   a_status_low: assert property (pready_o && !pwrite_i && paddr_i == spi_port_pkg::stat_addr
      |-> prdata_o[3:0] == 4'h0) else $error("reserved bits set");
   // =====
   // pins
   a_idle_undriven: assert property (!spi_active_o [*2] |-> !sck_oe_o && !mosi_oe_o)
      else $error("idle master drives");
   a_unsel_undriven: assert property (ss_n_i [*5] |-> !miso_oe_o)
      else $error("unselected slave drives");
   a_sck_hold: assert property (sck_oe_o && $changed(sck_o) |=> $stable(sck_o))
      else $error("clock half period short");
   c_error: cover property (pready_o && pslverr_o);
   c_xfer: cover property (spi_active_o ##1 !spi_active_o);
   c_slave: cover property ($rose(miso_oe_o));
endmodule

bind spi_port spi_port_asserts spi_port_asserts_i (.ref_clk_i, .resetn_i, .psel_i, .penable_i,
   .pwrite_i, .paddr_i, .prdata_o, .pready_o, .pslverr_o, .sck_o, .sck_oe_o, .mosi_oe_o,
   .miso_oe_o, .ss_n_i, .spi_active_o);

// ### dv/spi_far_dev.sv
// far-side serial slave: samples on rise, msb first, may skip the first fall
`timescale 1ns/10ps
module spi_far_dev (
   // serial pins
   input wire logic sck_i,
   input wire logic mosi_i,
   input wire logic sel_n_i,
   input wire logic skip_first_i,
   output logic miso_o,
   // byte side
   input wire logic [7:0] tx_i,
   output logic [7:0] rx_o
);
   logic [7:0] sh = 8'h00;
   logic first = 1'h0;
   // =====
   // shifting
   always @(negedge sel_n_i) begin
      sh = tx_i;
      first = 1'h1;
   end
   always @(posedge sck_i) if (!sel_n_i) rx_o = {rx_o[6:0], mosi_i};
   // with a high idle clock the first fall only launches the first bit
   always @(negedge sck_i) begin
      if (!sel_n_i && skip_first_i && first) first = 1'h0;
      else if (!sel_n_i) sh = {sh[6:0], 1'h0};
   end
   // released line shows the inverse of the last bit
   assign miso_o = sel_n_i ? ~sh[7] : sh[7];
endmodule

// ### dv/tb_spi_port.sv
// self-checking bench for the serial port
`timescale 1ns/10ps
module tb_spi_port;
   // =====
   // signals
   localparam logic [3:0] ca = spi_port_pkg::ctrl_addr;
   localparam logic [3:0] sa = spi_port_pkg::stat_addr;
   localparam logic [3:0] da = spi_port_pkg::data_addr;
   logic ref_clk_i = 1'h0, resetn_i = 1'h0, psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0;
   logic [3:0] paddr_i = 4'h0;
   logic [31:0] pwdata_i = 32'h0, prdata_o, q;
   logic pready_o, pslverr_o, sck_o, sck_oe_o, mosi_o, mosi_oe_o, miso_o, miso_oe_o;
   logic irq_o, spi_active_o, far_miso, err, sck_q = 1'h0;
   logic ss_n_i = 1'h1, sel_n = 1'h1, clock_polarity_pull = 1'h0;
   logic [7:0] far_tx = 8'h3C, far_rx;
   int num_errors = 0, tests_run = 0, cnt = 0, per = 0;
   int divs[4] = '{4, 16, 64, 128};
   wire sck_i = sck_oe_o ? sck_o : clock_polarity_pull;
   wire mosi_i = mosi_oe_o ? mosi_o : 1'h0;
   wire miso_i = miso_oe_o ? miso_o : far_miso;
   always #5 ref_clk_i = ~ref_clk_i;
   spi_port spi_port_i (.ref_clk_i, .resetn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
      .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .sck_i, .sck_o, .sck_oe_o, .mosi_i,
      .mosi_o, .mosi_oe_o, .miso_i, .miso_o, .miso_oe_o, .ss_n_i, .irq_o, .spi_active_o);
   spi_far_dev spi_far_dev_i (.sck_i, .mosi_i, .sel_n_i(sel_n), .skip_first_i(clock_polarity_pull),
      .miso_o(far_miso),
      .tx_i(far_tx), .rx_o(far_rx));
   // =====
   // clock period monitor
   always @(posedge ref_clk_i) begin
      cnt <= cnt + 1;
      sck_q <= sck_o;
      if (sck_oe_o && sck_o && !sck_q) begin
         per <= cnt + 1;
         cnt <= 0;
      end
   end
   // =====
   // tasks
   task chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      psel_i <= 1'h1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= {24'h000000, d};
      @(posedge ref_clk_i);
      penable_i <= 1'h1;
      do @(posedge ref_clk_i); while (pready_o !== 1'h1);
      q = prdata_o;
      err = pslverr_o;
      psel_i <= 1'h0;
      penable_i <= 1'h0;
   endtask
   task rc(input logic [3:0] a, input logic [7:0] e);
      bus(1'h0, a, 8'h00);
      chk(q, {24'h000000, e});
   endtask
   task wait_idle;
      repeat (3) @(posedge ref_clk_i);
      while (spi_active_o !== 1'h0) @(posedge ref_clk_i);
      repeat (3) @(posedge ref_clk_i);
   endtask
   task xfer(input logic [7:0] d);
      sel_n <= 1'h0;
      bus(1'h1, da, d);
      wait_idle;
      sel_n <= 1'h1;
   endtask
   task end_of_test;
      if (num_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge ref_clk_i);
      num_errors++;
      end_of_test;
   end
   // =====
   // tests
   initial begin
      repeat (6) @(posedge ref_clk_i);
      resetn_i <= 1'h1;
      rc(ca, 8'h00);
      rc(sa, 8'h00);
      rc(da, 8'h00);
      bus(1'h1, sa, 8'h0F);
      rc(sa, 8'h00);
      bus(1'h0, 4'hC, 8'h00);
      chk({31'h0, err}, 32'h1);
      ss_n_i <= 1'h0;
      for (int r = 0; r < 4; r++) begin
         bus(1'h1, ca, 8'hD0 + 8'(r));
         xfer(8'hA5 + 8'(r));
         chk(per, divs[r]);
         chk(far_rx, 8'hA5 + 8'(r));
         rc(da, 8'h3C);
         rc(sa, 8'h80);
         bus(1'h1, sa, 8'h80);
         rc(sa, 8'h00);
      end
      far_tx <= 8'h96;
      bus(1'h1, ca, 8'hD0);
      sel_n <= 1'h0;
      bus(1'h1, da, 8'h5A);
      bus(1'h1, da, 8'hFF);
      wait_idle;
      sel_n <= 1'h1;
      chk(far_rx, 8'h5A);
      rc(sa, 8'hC0);
      far_tx <= 8'h69;
      xfer(8'h11);
      chk(far_rx, 8'h11);
      rc(sa, 8'hE0);
      rc(da, 8'h96);
      bus(1'h1, sa, 8'hF0);
      rc(sa, 8'h00);
      far_tx <= 8'h0F;
      bus(1'h1, ca, 8'hF0);
      xfer(8'h01);
      chk(far_rx, 8'h80);
      rc(da, 8'hF0);
      bus(1'h1, sa, 8'hF0);
      clock_polarity_pull <= 1'h1;
      far_tx <= 8'hC3;
      bus(1'h1, ca, 8'hDC);
      xfer(8'h3A);
      chk(far_rx, 8'h3A);
      rc(da, 8'hC3);
      rc(sa, 8'h80);
      bus(1'h1, sa, 8'hF0);
      clock_polarity_pull <= 1'h0;
      ss_n_i <= 1'h1;
      bus(1'h1, ca, 8'h50);
      ss_n_i <= 1'h0;
      repeat (6) @(posedge ref_clk_i);
      chk({31'h0, irq_o}, 32'h1);
      rc(sa, 8'h10);
      rc(ca, 8'h00);
      bus(1'h1, sa, 8'h10);
      rc(sa, 8'h00);
      ss_n_i <= 1'h1;
      bus(1'h1, ca, 8'h40);
      ss_n_i <= 1'h0;
      repeat (6) @(posedge ref_clk_i);
      chk({31'h0, miso_oe_o}, 32'h1);
      chk({31'h0, miso_o}, 32'h0);
      ss_n_i <= 1'h1;
      repeat (6) @(posedge ref_clk_i);
      chk({31'h0, miso_oe_o}, 32'h0);
      end_of_test;
   end
endmodule
